// ===== sssrm_checker.sv
`timescale 1ns/1ps
module sssrm_checker #(
    parameter int TICK_CYC = 4
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic stop_request,
    input wire logic torque_cutoff,
    input wire logic stop_active_flag,
    input wire logic stop_completed_flag,
    input wire logic cutoff_active_flag,
    input wire logic ack_permitted,
    input wire logic decel_request
);
    import sssrm_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // Everything the acknowledge releases goes in one step.
    sequence s_all_clear;
        !stop_completed_flag && !cutoff_active_flag && !torque_cutoff;
    endsequence
    sequence s_start;
        $rose(stop_active_flag) && $rose(decel_request);
    endsequence

    a_start_pair: assert property ($rose(decel_request) |-> s_start)
        else $error("stop start not paired");
    a_active_hold: assert property (
        stop_active_flag && !ack_permitted |=> stop_active_flag)
        else $error("stop active dropped early");
    a_ack_clears: assert property ($fell(stop_active_flag) |-> s_all_clear)
        else $error("flags not cleared together");
    a_cut_flag: assert property (cutoff_active_flag == torque_cutoff)
        else $error("cutoff flag differs from cutoff");
    a_done_active: assert property (
        stop_completed_flag |-> stop_active_flag)
        else $error("completed without active");
    a_ack_gate: assert property (
        ack_permitted |-> stop_completed_flag && !$past(stop_request, 3))
        else $error("ack permitted too early");
    a_decel_end: assert property ($rose(torque_cutoff) |=> !decel_request)
        else $error("ramp request outlives cutoff");
    a_cut_holds: assert property (
        torque_cutoff && stop_active_flag |=> torque_cutoff || !stop_active_flag)
        else $error("cutoff released before ack");
    a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    a_wait_answer: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus access not answered");
endmodule : sssrm_checker

bind sssrm_top sssrm_checker #(.TICK_CYC(TICK_CYC)) u_chk (
    .core_clk(core_clk), .rst_n(rst_n), .avs_read(avs_read),
    .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
    .stop_request(stop_request), .torque_cutoff(torque_cutoff),
    .stop_active_flag(stop_active_flag),
    .stop_completed_flag(stop_completed_flag),
    .cutoff_active_flag(cutoff_active_flag),
    .ack_permitted(ack_permitted), .decel_request(decel_request)
);

// ===== sssrm_drive_model.sv
`timescale 1ns/1ps
// Drive side: ramps the speed down on command, coasts or brakes after cutoff.
module sssrm_drive_model #(
    parameter logic [15:0] TOP_SPEED = 16'h03e8,
    parameter logic [15:0] OWN_RAMP = 16'h0019
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic decel_request,
    input wire logic [sssrm_pkg::SW-1:0] ramp_set_one,
    input wire logic torque_cutoff,
    input wire logic brake_control_output,
    input wire logic stall,
    output logic [sssrm_pkg::SW-1:0] measured_speed
);
    import sssrm_pkg::*;
    logic [SW-1:0] step;

    // A stalled drive ignores the ramp; that is how faults are provoked.
    always_comb begin
        step = 16'h0000;
        if (brake_control_output) begin
            step = 16'h0014;
        end else if (torque_cutoff) begin
            step = 16'h0001;
        end else if (decel_request && !stall) begin
            step = (ramp_set_one == 16'h0000) ? OWN_RAMP : ramp_set_one;
        end
    end

    // Speed returns to the top value once the drive is released.
    always_ff @(posedge core_clk) begin
        if (!rst_n || !(decel_request || torque_cutoff)) begin
            measured_speed <= TOP_SPEED;
        end else if (measured_speed > step) begin
            measured_speed <= measured_speed - step;
        end else begin
            measured_speed <= 16'h0000;
        end
    end
endmodule : sssrm_drive_model

// ===== sssrm_env.sv
`timescale 1ns/1ps
module sssrm_env (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic tick,
    input wire logic [sssrm_pkg::SW-1:0] up_init,
    input wire logic [sssrm_pkg::SW-1:0] lo_init,
    input wire logic [sssrm_pkg::SW-1:0] slope,
    input wire logic [sssrm_pkg::SW-1:0] speed,
    output logic hit
);
    import sssrm_pkg::*;

    logic [SW-1:0] up_q;
    logic [SW-1:0] lo_q;

    // Both limits fall with the deceleration slope and stop at zero,
    // so the envelope follows the ramp instead of a fixed band.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            up_q <= '0;
            lo_q <= '0;
        end else if (load) begin
            up_q <= up_init;
            lo_q <= lo_init;
        end else if (tick) begin
            up_q <= (up_q > slope) ? up_q - slope : '0;
            lo_q <= (lo_q > slope) ? lo_q - slope : '0;
        end
    end

    // Touching a limit counts; a lower limit of zero never trips.
    assign hit = (speed >= up_q) || (lo_q != '0 && speed <= lo_q);
endmodule : sssrm_env

// ===== sssrm_pkg.sv
package sssrm_pkg;
    // Clock and supervision time base.
    localparam int CLK_PERIOD_NS = 40;
    localparam int TICK_NS = 1000000;
    localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
    localparam int TW = 16;
    localparam int SW = 16;

    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
    localparam logic [7:0] OFS_DEADLINE = 8'h10;
    localparam logic [7:0] OFS_EXTRA = 8'h14;
    localparam logic [7:0] OFS_ZERO_SPD = 8'h18;
    localparam logic [7:0] OFS_BRK_DLY = 8'h1c;
    localparam logic [7:0] OFS_BRK_ZERO = 8'h20;
    localparam logic [7:0] OFS_ENV_UP = 8'h24;
    localparam logic [7:0] OFS_ENV_LO = 8'h28;
    localparam logic [7:0] OFS_RESP = 8'h2c;
    localparam logic [7:0] OFS_BRK_SPD = 8'h30;
    localparam logic [7:0] OFS_RAMP1 = 8'h34;

    // Control register fields.
    localparam int CTRL_TYPE = 0;
    localparam int CTRL_BRAKE = 1;
    localparam int CTRL_AT_SPD = 2;
    localparam logic [2:0] CTRL_RST = 3'h0;

    // Interrupt event bit positions.
    localparam int IRQ_START = 0;
    localparam int IRQ_CUT = 1;
    localparam int IRQ_DONE = 2;
    localparam int IRQ_FAULT = 3;
    localparam int NIRQ = 4;

    // Reset values of configuration words, in supervision ticks or speed.
    localparam logic [TW-1:0] RST_TIME = 16'h0000;
    localparam logic [SW-1:0] RST_SPEED = 16'h0000;

    typedef enum logic [2:0] {
        ST_IDLE, ST_RESP, ST_RAMP, ST_TRIG, ST_CUT, ST_DONE
    } sssrm_state_e;
endpackage : sssrm_pkg

// ===== sssrm_tmr.sv
`timescale 1ns/1ps
module sssrm_tmr (
    input wire logic core_clk,
    input wire logic rst_n,
    sssrm_tmr_if.tmr t
);
    import sssrm_pkg::*;

    logic [TW-1:0] cnt_q;
    logic busy_q;
    logic exp_q;

    // A zero length expires at once; otherwise after len ticks.
    // Expiry is a level that holds until the next start.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cnt_q <= '0;
            busy_q <= 1'b0;
            exp_q <= 1'b0;
        end else if (t.start) begin
            cnt_q <= t.len;
            busy_q <= (t.len != '0);
            exp_q <= (t.len == '0);
        end else if (busy_q && t.tick) begin
            cnt_q <= cnt_q - 16'h0001;
            if (cnt_q == 16'h0001) begin
                busy_q <= 1'b0;
                exp_q <= 1'b1;
            end
        end
    end

    assign t.expired = exp_q;
endmodule : sssrm_tmr

// ===== sssrm_tmr_if.sv
`timescale 1ns/1ps
// Start, length and expiry of one tick-based delay counter.
interface sssrm_tmr_if;
    import sssrm_pkg::*;
    logic start;
    logic [TW-1:0] len;
    logic tick;
    logic expired;
    modport ctl (output start, output len, output tick, input expired);
    modport tmr (input start, input len, input tick, output expired);
endinterface : sssrm_tmr_if

// ===== sssrm_top.sv
// Decided for this implementation: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
// What this block does
// - Timer or envelope supervision chosen by configuration.
// - Timer type: request starts deadline, sets active.
// - Zero speed: cutoff, cutoff flag, completed flag.
// - Acknowledge only when completed and request withdrawn.
// - Brake enabled: brake fires with zero-speed cutoff.
// - Negative brake delay: brake first, cutoff later.
// - Non-negative brake delay: brake and cutoff together.
// - With brake, completed after brake-to-zero time.
// - Optional extra delay before cutoff.
// - Deadline expiry cuts torque at once while speed is above the threshold.
// - Acknowledge clears cutoff, stop and all flags.
// - Envelope type: compare limits after response time.
// - Envelope limit touched: cutoff at once.
// - Envelope type: zero speed completes the stop.
// - Brake pair may trigger at own speed.
module sssrm_top #(
    parameter int TICK_CYC = sssrm_pkg::TICK_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic stop_request,
    input wire logic stop_ack,
    input wire logic [sssrm_pkg::SW-1:0] measured_speed,
    output logic torque_cutoff,
    output logic brake_control_output,
    output logic stop_active_flag,
    output logic stop_completed_flag,
    output logic cutoff_active_flag,
    output logic ack_permitted,
    output logic decel_request,
    output logic [sssrm_pkg::SW-1:0] ramp_set_one,
    output logic irq
);
    import sssrm_pkg::*;

    sssrm_state_e st_q;
    logic [2:0] ctrl_q;
    logic [TW-1:0] deadline_q, extra_q, brk_zero_q, resp_q;
    logic [SW-1:0] zero_spd_q, env_up_q, env_lo_q, brk_spd_q, ramp1_q;
    logic [15:0] brk_dly_q;
    logic [NIRQ-1:0] irq_stat_q, irq_mask_q, irq_ev;
    logic [31:0] tick_cnt_q;
    logic tick_q;
    logic req_m_q, req_s_q, ack_m_q, ack_s_q, ack_p_q;
    logic [SW-1:0] spd_m_q, spd_s_q;
    logic wait_q;
    logic wr_go;
    logic [31:0] rd_mux;
    logic fault_q;
    logic timed, brake_en, neg_dly, at_zero, env_hit;
    logic [SW-1:0] thr;
    logic [16:0] cut_len;
    logic ev_req, ev_run, ev_zero, ev_fault, ev_cut, ev_done, ev_ack;

    sssrm_tmr_if dl_if ();
    sssrm_tmr_if a_if ();
    sssrm_tmr_if b_if ();

    // Deadline, response-or-cutoff delay, and brake-to-zero counters.
    sssrm_tmr u_dl (.core_clk(core_clk), .rst_n(rst_n), .t(dl_if));
    sssrm_tmr u_a (.core_clk(core_clk), .rst_n(rst_n), .t(a_if));
    sssrm_tmr u_b (.core_clk(core_clk), .rst_n(rst_n), .t(b_if));

    sssrm_env u_env (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .load(ev_run),
        .tick(tick_q),
        .up_init(env_up_q),
        .lo_init(env_lo_q),
        .slope(ramp1_q),
        .speed(spd_s_q),
        .hit(env_hit)
    );

    // Supervision tick divider; all configured times count these ticks.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tick_cnt_q <= '0;
            tick_q <= 1'b0;
        end else if (tick_cnt_q == 32'(TICK_CYC - 1)) begin
            tick_cnt_q <= '0;
            tick_q <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h1;
            tick_q <= 1'b0;
        end
    end

    // Pin synchronisers. The speed word may skew by one sample across
    // bits; the drive is expected to change it slowly against our clock.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            req_m_q <= 1'b0;
            req_s_q <= 1'b0;
            ack_m_q <= 1'b0;
            ack_s_q <= 1'b0;
            ack_p_q <= 1'b0;
            spd_m_q <= '0;
            spd_s_q <= '0;
        end else begin
            req_m_q <= stop_request;
            req_s_q <= req_m_q;
            ack_m_q <= stop_ack;
            ack_s_q <= ack_m_q;
            ack_p_q <= ack_s_q;
            spd_m_q <= measured_speed;
            spd_s_q <= spd_m_q;
        end
    end

    // Decode of configuration and the stop events of this cycle.
    always_comb begin
        timed = !ctrl_q[CTRL_TYPE];
        brake_en = ctrl_q[CTRL_BRAKE];
        neg_dly = brake_en && brk_dly_q[15];
        thr = (brake_en && ctrl_q[CTRL_AT_SPD]) ? brk_spd_q : zero_spd_q;
        at_zero = (spd_s_q <= thr);
        ev_req = (st_q == ST_IDLE) && req_s_q;
        ev_zero = (st_q == ST_RESP || st_q == ST_RAMP) && at_zero;
        ev_fault = (st_q == ST_RESP || st_q == ST_RAMP) && !at_zero
            && (timed ? dl_if.expired
                      : (st_q == ST_RAMP && env_hit));
        ev_run = (st_q == ST_RESP) && a_if.expired && !ev_zero && !ev_fault;
        ev_cut = (st_q == ST_TRIG) && a_if.expired;
        ev_done = (st_q == ST_CUT) && (!brake_en || b_if.expired);
        ev_ack = ack_permitted && ack_s_q && !ack_p_q && !req_s_q;
        // Cutoff waits the extra delay plus the lead of a negative brake.
        cut_len = {1'b0, extra_q}
            + (neg_dly ? {1'b0, 16'h0 - brk_dly_q} : 17'h0);
    end

    // Counter starts follow the events directly so expiry is fresh.
    assign dl_if.start = ev_req && timed;
    assign dl_if.len = deadline_q;
    assign dl_if.tick = tick_q;
    assign a_if.start = ev_req || ev_zero;
    assign a_if.len = ev_zero ? (cut_len[16] ? 16'hffff : cut_len[15:0])
                              : resp_q;
    assign a_if.tick = tick_q;
    assign b_if.start = (ev_zero && neg_dly) || (ev_fault && brake_en)
        || (ev_cut && brake_en && !neg_dly);
    assign b_if.len = brk_zero_q;
    assign b_if.tick = tick_q;

    // Stop sequence state.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_q <= ST_IDLE;
        end else begin
            case (st_q)
                ST_IDLE: if (ev_req) st_q <= ST_RESP;
                ST_RESP, ST_RAMP: begin
                    if (ev_zero) begin
                        st_q <= ST_TRIG;
                    end else if (ev_fault) begin
                        st_q <= ST_CUT;
                    end else if (ev_run) begin
                        st_q <= ST_RAMP;
                    end
                end
                ST_TRIG: if (ev_cut) st_q <= ST_CUT;
                ST_CUT: if (ev_done) st_q <= ST_DONE;
                ST_DONE: if (ev_ack) st_q <= ST_IDLE;
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // Drive-facing outputs and indications.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            torque_cutoff <= 1'b0;
            brake_control_output <= 1'b0;
            stop_active_flag <= 1'b0;
            stop_completed_flag <= 1'b0;
            cutoff_active_flag <= 1'b0;
            decel_request <= 1'b0;
            fault_q <= 1'b0;
        end else if (ev_ack) begin
            torque_cutoff <= 1'b0;
            brake_control_output <= 1'b0;
            stop_active_flag <= 1'b0;
            stop_completed_flag <= 1'b0;
            cutoff_active_flag <= 1'b0;
            decel_request <= 1'b0;
        end else begin
            if (ev_req) begin
                stop_active_flag <= 1'b1;
                decel_request <= 1'b1;
                fault_q <= 1'b0;
            end
            if (ev_cut || ev_fault) begin
                torque_cutoff <= 1'b1;
                cutoff_active_flag <= 1'b1;
                decel_request <= 1'b0;
            end
            if (b_if.start) begin
                brake_control_output <= 1'b1;
            end
            if (ev_fault) begin
                fault_q <= 1'b1;
            end
            if (ev_done) begin
                stop_completed_flag <= 1'b1;
            end
        end
    end

    // Acknowledge window seen by the request source.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ack_permitted <= 1'b0;
        end else begin
            ack_permitted <= (st_q == ST_DONE) && !req_s_q && !ev_ack;
        end
    end

    // The drive reads the deceleration word; zero selects its own ramp.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ramp_set_one <= RST_SPEED;
        end else begin
            ramp_set_one <= ramp1_q;
        end
    end

    // Avalon slave: waitrequest drops for one cycle after a request is
    // seen, so every access finishes at the second edge.
    assign wr_go = avs_write && !wait_q;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= !((avs_read || avs_write) && wait_q);
        end
    end

    assign avs_waitrequest = wait_q;

    // Read mux; unmapped offsets read zero.
    always_comb begin
        rd_mux = 32'h0;
        case (avs_address)
            OFS_CTRL: rd_mux = {29'h0, ctrl_q};
            OFS_STATUS: rd_mux = {23'h0, fault_q, 3'(st_q), ack_permitted,
                brake_control_output, torque_cutoff, stop_completed_flag,
                stop_active_flag};
            OFS_IRQ_STAT: rd_mux = {28'h0, irq_stat_q};
            OFS_IRQ_MASK: rd_mux = {28'h0, irq_mask_q};
            OFS_DEADLINE: rd_mux = {16'h0, deadline_q};
            OFS_EXTRA: rd_mux = {16'h0, extra_q};
            OFS_ZERO_SPD: rd_mux = {16'h0, zero_spd_q};
            OFS_BRK_DLY: rd_mux = {16'h0, brk_dly_q};
            OFS_BRK_ZERO: rd_mux = {16'h0, brk_zero_q};
            OFS_ENV_UP: rd_mux = {16'h0, env_up_q};
            OFS_ENV_LO: rd_mux = {16'h0, env_lo_q};
            OFS_RESP: rd_mux = {16'h0, resp_q};
            OFS_BRK_SPD: rd_mux = {16'h0, brk_spd_q};
            OFS_RAMP1: rd_mux = {16'h0, ramp1_q};
            default: rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0;
        end else if (avs_read && wait_q) begin
            avs_readdata <= rd_mux;
        end
    end

    // Configuration writes. Only the low byte lanes carry data; a
    // configuration change mid-stop is accepted at once, but times and limits
    // already loaded into a counter or the envelope keep their old value.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ctrl_q <= CTRL_RST;
            irq_mask_q <= '0;
            deadline_q <= RST_TIME;
            extra_q <= RST_TIME;
            brk_zero_q <= RST_TIME;
            resp_q <= RST_TIME;
            brk_dly_q <= RST_TIME;
            zero_spd_q <= RST_SPEED;
            env_up_q <= RST_SPEED;
            env_lo_q <= RST_SPEED;
            brk_spd_q <= RST_SPEED;
            ramp1_q <= RST_SPEED;
        end else if (wr_go && avs_byteenable[1:0] == 2'h3) begin
            case (avs_address)
                OFS_CTRL: ctrl_q <= avs_writedata[2:0];
                OFS_IRQ_MASK: irq_mask_q <= avs_writedata[NIRQ-1:0];
                OFS_DEADLINE: deadline_q <= avs_writedata[15:0];
                OFS_EXTRA: extra_q <= avs_writedata[15:0];
                OFS_ZERO_SPD: zero_spd_q <= avs_writedata[15:0];
                OFS_BRK_DLY: brk_dly_q <= avs_writedata[15:0];
                OFS_BRK_ZERO: brk_zero_q <= avs_writedata[15:0];
                OFS_ENV_UP: env_up_q <= avs_writedata[15:0];
                OFS_ENV_LO: env_lo_q <= avs_writedata[15:0];
                OFS_RESP: resp_q <= avs_writedata[15:0];
                OFS_BRK_SPD: brk_spd_q <= avs_writedata[15:0];
                OFS_RAMP1: ramp1_q <= avs_writedata[15:0];
                default: ;
            endcase
        end
    end

    // Sticky events, write one to clear; a new event beats the clear.
    assign irq_ev = {ev_fault, ev_done, ev_cut || ev_fault, ev_req};

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            irq_stat_q <= '0;
        end else begin
            for (int i = 0; i < NIRQ; i++) begin
                if (irq_ev[i]) begin
                    irq_stat_q[i] <= 1'b1;
                end else if (wr_go && avs_address == OFS_IRQ_STAT
                             && avs_byteenable[0] && avs_writedata[i]) begin
                    irq_stat_q[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_q & irq_mask_q);
        end
    end
endmodule : sssrm_top

// ===== tb_safe_stop_ramp_monitor.sv
`timescale 1ns/1ps
module tb_safe_stop_ramp_monitor;
    import sssrm_pkg::*;
    localparam int T = 4;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, torque_cutoff, brake_control_output, irq;
    logic stop_request = 1'b0;
    logic stop_ack = 1'b0;
    logic stall = 1'b0;
    logic [15:0] measured_speed, ramp_set_one, spd_cut;
    logic stop_active_flag, stop_completed_flag, cutoff_active_flag;
    logic ack_permitted, decel_request;
    int fail_count = 0;
    int total_checks = 0;
    int cyc = 0;
    int t_req = -1, t_brk = -1, t_cut = -1, t_done = -1, t_zero = -1;

    always #20 core_clk = ~core_clk;

    sssrm_top #(.TICK_CYC(T)) uut (
        .core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .stop_request(stop_request), .stop_ack(stop_ack),
        .measured_speed(measured_speed), .torque_cutoff(torque_cutoff),
        .brake_control_output(brake_control_output),
        .stop_active_flag(stop_active_flag),
        .stop_completed_flag(stop_completed_flag),
        .cutoff_active_flag(cutoff_active_flag),
        .ack_permitted(ack_permitted), .decel_request(decel_request),
        .ramp_set_one(ramp_set_one), .irq(irq)
    );

    sssrm_drive_model drive (
        .core_clk(core_clk), .rst_n(rst_n), .decel_request(decel_request),
        .ramp_set_one(ramp_set_one), .torque_cutoff(torque_cutoff),
        .brake_control_output(brake_control_output), .stall(stall),
        .measured_speed(measured_speed)
    );

    // First rise of brake, cutoff, completed flag and low speed since the last request, and a hang guard.
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (brake_control_output === 1'b1 && t_brk < 0) t_brk <= cyc;
        if (torque_cutoff === 1'b1 && t_cut < 0) begin
            t_cut <= cyc;
            spd_cut <= measured_speed;
        end
        if (stop_completed_flag === 1'b1 && t_done < 0) t_done <= cyc;
        if (measured_speed <= 16'h0064 && t_zero < 0) t_zero <= cyc;
        if (cyc == 20000) begin
            fail_count++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk

    task automatic chk_rng(input integer v, input int lo, input int hi);
        total_checks++;
        if ((v >= lo && v <= hi) !== 1'b1) begin
            fail_count++;
            $display("MISMATCH t=%0t got %h exp %h..%h", $time, v, lo, hi);
        end
    endtask : chk_rng

    // One access; the request stands until waitrequest is sampled low.
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [15:0] d, output logic [31:0] q);
        @(posedge core_clk);
        avs_write <= w;
        avs_read <= !w;
        avs_address <= a;
        avs_writedata <= {16'h0000, d};
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0) @(posedge core_clk);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 16'h0000, q);
        chk(q, e);
    endtask : rd

    // Configure one stop and raise the request.
    task automatic go(input logic [15:0] c, dl, ex, dy, bz, up,
                      input logic st);
        wr(OFS_CTRL, c);
        wr(OFS_DEADLINE, dl);
        wr(OFS_EXTRA, ex);
        wr(OFS_BRK_DLY, dy);
        wr(OFS_BRK_ZERO, bz);
        wr(OFS_ENV_UP, up);
        @(posedge core_clk);
        stall <= st;
        {t_brk, t_cut, t_done, t_zero} <= {4{32'hffffffff}};
        t_req <= cyc;
        stop_request <= 1'b1;
        @(posedge core_clk);
    endtask : go

    task automatic pulse_ack();
        stop_ack <= 1'b1;
        repeat (4) @(posedge core_clk);
        stop_ack <= 1'b0;
        repeat (6) @(posedge core_clk);
    endtask : pulse_ack

    // An early acknowledge is ignored; a late one clears everything.
    task automatic end_stop();
        while (stop_completed_flag !== 1'b1) @(posedge core_clk);
        pulse_ack();
        chk({stop_active_flag, stop_completed_flag}, 2'b11);
        stop_request <= 1'b0;
        while (ack_permitted !== 1'b1) @(posedge core_clk);
        chk(stop_active_flag, 1'b1);
        pulse_ack();
        chk({stop_active_flag, stop_completed_flag, torque_cutoff,
             cutoff_active_flag, brake_control_output}, 5'h00);
    endtask : end_stop

    task automatic s_regs();
        rd(OFS_CTRL, 32'h0);
        wr(8'hfc, 16'hffff);
        rd(8'hfc, 32'h0);
        wr(OFS_ZERO_SPD, 16'h0064);
        wr(OFS_RESP, 16'h0002);
        wr(OFS_BRK_SPD, 16'h01f4);
        wr(OFS_RAMP1, 16'h0032);
        repeat (2) @(posedge core_clk);
        chk(ramp_set_one, 16'h0032);
    endtask : s_regs

    // Timer type with the done event as the only unmasked interrupt.
    task automatic s_timer();
        wr(OFS_IRQ_MASK, 16'h0004);
        go(16'h0000, 16'h00c8, 16'h0, 16'h0, 16'h0, 16'h0, 1'b0);
        repeat (5) @(posedge core_clk);
        chk({stop_active_flag, decel_request, irq}, 3'b110);
        while (stop_completed_flag !== 1'b1) @(posedge core_clk);
        repeat (3) @(posedge core_clk);
        chk(irq, 1'b1);
        wr(OFS_IRQ_STAT, 16'h000f);
        repeat (2) @(posedge core_clk);
        chk(irq, 1'b0);
        end_stop();
        chk_rng(spd_cut, 0, 100);
        chk_rng(t_brk, -1, -1);
    endtask : s_timer

    task automatic s_faults();
        go(16'h0000, 16'h0003, 16'h0, 16'h0, 16'h0, 16'h0, 1'b1);
        end_stop();
        chk_rng(spd_cut, 101, 65535);
        chk_rng(t_cut - t_req, 2 * T, 3 * T + 10);
        go(16'h0001, 16'h00c8, 16'h0, 16'h0, 16'h0, 16'h0384, 1'b1);
        end_stop();
        chk_rng(spd_cut, 101, 65535);
        chk_rng(t_cut - t_req, T + 2, 3 * T + 10);
        go(16'h0001, 16'h00c8, 16'h0, 16'h0, 16'h0, 16'h07d0, 1'b0);
        end_stop();
        chk_rng(spd_cut, 0, 100);
    endtask : s_faults

    task automatic s_brakes();
        go(16'h0006, 16'h00c8, 16'h0, 16'hfffd, 16'h0002, 16'h0, 1'b0);
        end_stop();
        chk_rng(t_brk, 1, 1 << 30);
        chk_rng(t_cut - t_brk, 2 * T, 4 * T + 2);
        chk_rng(t_done - t_brk, T, 3 * T + 2);
        chk_rng(t_zero - t_brk, 1, 1 << 30);
        wr(OFS_RAMP1, 16'h0000);
        repeat (2) @(posedge core_clk);
        chk(ramp_set_one, 16'h0000);
        go(16'h0002, 16'h00c8, 16'h0002, 16'h0, 16'h0001, 16'h0, 1'b0);
        end_stop();
        chk_rng(t_cut - t_brk, 0, 0);
        chk_rng(t_cut - t_zero, T + 2, 3 * T + 8);
        wr(OFS_RAMP1, 16'h0032);
    endtask : s_brakes

    initial begin
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        s_regs();
        s_timer();
        s_faults();
        s_brakes();
        summarize();
    end
endmodule : tb_safe_stop_ramp_monitor
